/* include/rst_clk_pkg.sv */
// Constants for the reset and clock gating block
package rst_clk_pkg;
	localparam logic [7:0]  PROC_MODE_ADDR   = 8'h5e;
	localparam int          SOFT_RESET_BIT   = 3;
	localparam logic [15:0] RESET_VECTOR_LO  = 16'hfffe;
	localparam logic [15:0] RESET_VECTOR_HI  = 16'hffff;
	localparam int          CLK_FREQ_MHZ     = 40;
	localparam int          RESET_MIN_US     = 2;
	localparam int          RESET_MIN_CYCLES = RESET_MIN_US * CLK_FREQ_MHZ;
	localparam int          POST_RESET_CYCLES = 8;
	localparam int          DIV_STAGES       = 9;
	localparam logic [8:0]  DIV_RESET        = 9'h000;
endpackage : rst_clk_pkg

/* core/reset_and_clock_gating.sv */
// Reset sequencing and clock enable generation
`timescale 1ns/100ps
module reset_and_clock_gating #(
	parameter int POST_CYCLES = rst_clk_pkg::POST_RESET_CYCLES,
	parameter int DIV_STAGES  = rst_clk_pkg::DIV_STAGES
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  reg_write,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  stop_instruction,
	input  wire logic                  wait_instruction,
	input  wire logic                  wake_event,
	input  wire logic                  ready_n,
	input  wire logic                  hold_accepted,
	input  wire logic                  bus_wait_request,
	output logic                       periph_reset_n,
	output logic                       ram_reset_n,
	output logic                       vector_fetch,
	output logic [15:0]                vector_addr,
	output logic                       main_clk_en,
	output logic                       cpu_clk_en,
	output logic                       clock_out,
	output logic [DIV_STAGES-1:0]      peripheral_divided_clocks
);

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	// Post-reset counter is eight bits wide
	if (POST_CYCLES < 1 || POST_CYCLES > 255) begin : g_bad_post
		$error("reset_and_clock_gating: POST_CYCLES out of range");
	end

	// At least two divider stages, at most a 16-bit count
	if (DIV_STAGES < 2 || DIV_STAGES > 16) begin : g_bad_div
		$error("reset_and_clock_gating: DIV_STAGES out of range");
	end

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_RESET,
		ST_POST,
		ST_VEC_LO,
		ST_RUN
	} seq_t;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_WAIT,
		PM_STOP
	} pmode_t;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Write to the processor mode register with the software reset bit set
	function automatic logic f_is_soft_reset(
		input logic       write,
		input logic [7:0] addr,
		input logic [7:0] data
	);
		logic hit;
		hit = 1'b0;
		if (!write)
			hit = 1'b0;
		else if (addr == rst_clk_pkg::PROC_MODE_ADDR)
			hit = data[rst_clk_pkg::SOFT_RESET_BIT];
		else
			hit = 1'b0;
		return hit;
	endfunction : f_is_soft_reset

	// Last count of the post-reset sequence
	function automatic logic f_post_done(
		input logic [7:0] count,
		input int         limit
	);
		return count == 8'(limit - 1);
	endfunction : f_post_done

	// Main clock runs only in run mode and without a ready request
	function automatic logic f_main_enable(
		input pmode_t mode,
		input logic   rdy_n
	);
		return mode == PM_RUN && rdy_n;
	endfunction : f_main_enable

	// CPU clock also stops for bus unit waits and accepted hold
	function automatic logic f_cpu_enable(
		input logic main_en,
		input logic wait_req,
		input logic hold
	);
		return main_en && !wait_req && !hold;
	endfunction : f_cpu_enable

	// Output clock stops low in stop mode only
	function automatic logic f_clock_out_next(
		input pmode_t mode,
		input logic   current
	);
		logic value;
		value = 1'b0;
		if (mode == PM_STOP)
			value = 1'b0;
		else
			value = ~current;
		return value;
	endfunction : f_clock_out_next

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	seq_t                  seq_reg, seq_next;
	logic [7:0]            post_cnt_reg, post_cnt_next;
	logic                  periph_rst_n_reg, periph_rst_n_next;
	logic                  vec_reg, vec_next;
	logic [15:0]           vaddr_reg, vaddr_next;
	logic                  soft_reset;

	assign soft_reset = f_is_soft_reset(reg_write, reg_addr, reg_wdata);

	always_comb begin
		seq_next          = seq_reg;
		post_cnt_next     = post_cnt_reg;
		periph_rst_n_next = periph_rst_n_reg;
		vec_next          = 1'b0;
		vaddr_next        = vaddr_reg;
		case (seq_reg)
			ST_RESET: begin
				// Held here by the async reset for as long as rst_n is low
				seq_next          = ST_POST;
				post_cnt_next     = 8'h00;
				periph_rst_n_next = 1'b1;
			end
			ST_POST: begin
				post_cnt_next = post_cnt_reg + 8'h01;
				if (f_post_done(post_cnt_reg, POST_CYCLES)) begin
					seq_next   = ST_VEC_LO;
					vec_next   = 1'b1;
					vaddr_next = rst_clk_pkg::RESET_VECTOR_LO;
				end
			end
			ST_VEC_LO: begin
				seq_next   = ST_RUN;
				vec_next   = 1'b1;
				vaddr_next = rst_clk_pkg::RESET_VECTOR_HI;
			end
			ST_RUN: begin
				vec_next = 1'b0;
			end
			default: begin
				seq_next = ST_RESET;
			end
		endcase
		if (soft_reset) begin
			// Restarts the sequencer as hardware reset does; RAM reset, vector_addr and divider are left as they are
			seq_next          = ST_RESET;
			periph_rst_n_next = 1'b0;
			vec_next          = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg          <= ST_RESET;
			post_cnt_reg     <= 8'h00;
			periph_rst_n_reg <= 1'b0;
			vec_reg          <= 1'b0;
			vaddr_reg        <= 16'h0000;
		end else begin
			seq_reg          <= seq_next;
			post_cnt_reg     <= post_cnt_next;
			periph_rst_n_reg <= periph_rst_n_next;
			vec_reg          <= vec_next;
			vaddr_reg        <= vaddr_next;
		end
	end

	// ----------------------------------------
	// RAM reset
	// ----------------------------------------
	// RAM only sees hardware reset, so software reset keeps its contents
	logic                  ram_rst_n_reg, ram_rst_n_next;

	always_comb begin
		ram_rst_n_next = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_rst_n_reg <= 1'b0;
		end else begin
			ram_rst_n_reg <= ram_rst_n_next;
		end
	end

	// ----------------------------------------
	// Power mode and clock gating
	// ----------------------------------------
	pmode_t                pmode_reg, pmode_next;
	logic                  main_en_reg, main_en_next;
	logic                  cpu_en_reg, cpu_en_next;
	logic                  clkout_reg, clkout_next;

	always_comb begin
		pmode_next = pmode_reg;
		// Wake wins over a stop or wait in the same cycle
		if (!periph_rst_n_reg || wake_event)
			pmode_next = PM_RUN;
		else if (stop_instruction)
			pmode_next = PM_STOP;
		else if (wait_instruction)
			pmode_next = PM_WAIT;
		// Main clock ignores hold; it keeps the bus unit alive during hold
		main_en_next = f_main_enable(pmode_next, ready_n);
		cpu_en_next  = f_cpu_enable(main_en_next, bus_wait_request, hold_accepted);
		// Output must come from a flop, so it runs at half the flop clock
		clkout_next  = f_clock_out_next(pmode_next, clkout_reg);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pmode_reg   <= PM_RUN;
			main_en_reg <= 1'b0;
			cpu_en_reg  <= 1'b0;
			clkout_reg  <= 1'b0;
		end else begin
			pmode_reg   <= pmode_next;
			main_en_reg <= main_en_next;
			cpu_en_reg  <= cpu_en_next;
			clkout_reg  <= clkout_next;
		end
	end

	// ----------------------------------------
	// Peripheral divider chain
	// ----------------------------------------
	// Binary counter: bit k toggles at clk/(2^(k+1)), the top bit is the slowest
	logic [DIV_STAGES-1:0] div_reg, div_next;

	always_comb begin
		if (main_en_reg)
			div_next = div_reg + DIV_STAGES'(1);
		else
			div_next = div_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a plain register copy, no logic after the flops
	assign periph_reset_n            = periph_rst_n_reg;
	assign ram_reset_n               = ram_rst_n_reg;
	assign vector_fetch              = vec_reg;
	assign vector_addr               = vaddr_reg;
	assign main_clk_en               = main_en_reg;
	assign cpu_clk_en                = cpu_en_reg;
	assign clock_out                 = clkout_reg;
	assign peripheral_divided_clocks = div_reg;
endmodule : reset_and_clock_gating

/* verification/rcg_monitor.sv */
// Checker for reset sequencing and clock gating
`timescale 1ns/100ps
module rcg_monitor #(parameter int POST_CYCLES = 8, parameter int DIV_STAGES = 9) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  reg_write,
	input wire logic                  stop_instruction,
	input wire logic                  wait_instruction,
	input wire logic                  wake_event,
	input wire logic                  ready_n,
	input wire logic                  hold_accepted,
	input wire logic                  bus_wait_request,
	input wire logic                  periph_reset_n,
	input wire logic                  ram_reset_n,
	input wire logic                  vector_fetch,
	input wire logic                  main_clk_en,
	input wire logic                  cpu_clk_en,
	input wire logic                  clock_out,
	input wire logic [7:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic [15:0]           vector_addr,
	input wire logic [DIV_STAGES-1:0] peripheral_divided_clocks
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_sw; reg_write && reg_addr == 8'h5e && reg_wdata[3] |=> !periph_reset_n; endproperty
	a_sw: assert property (p_sw) else $error("soft reset not taken");
	property p_post; $rose(periph_reset_n) |-> ##POST_CYCLES $rose(vector_fetch); endproperty
	a_post: assert property (p_post) else $error("post reset length wrong");
	property p_ram; ram_reset_n |=> ram_reset_n; endproperty
	a_ram: assert property (p_ram) else $error("ram reset by soft reset");
	property p_vec; $rose(vector_fetch) |-> vector_addr == 16'hfffe ##1 vector_addr == 16'hffff ##1 !vector_fetch;
	endproperty
	a_vec: assert property (p_vec) else $error("vector fetch order wrong");
	property p_src; cpu_clk_en |-> main_clk_en; endproperty
	a_src: assert property (p_src) else $error("cpu clock without main clock");
	property p_rdy; !ready_n || wait_instruction |=> !main_clk_en; endproperty
	a_rdy: assert property (p_rdy) else $error("main clock not halted");
	property p_hold; main_clk_en && ready_n && !stop_instruction && !wait_instruction |=> main_clk_en; endproperty
	a_hold: assert property (p_hold) else $error("main clock halted by hold");
	property p_cpu; bus_wait_request || hold_accepted |=> !cpu_clk_en; endproperty
	a_cpu: assert property (p_cpu) else $error("cpu clock not halted");
	property p_per; $rose(clock_out) |=> $fell(clock_out); endproperty
	a_per: assert property (p_per) else $error("clock out period wrong");
	property p_run; (!ready_n || hold_accepted || wait_instruction) && clock_out |=> !clock_out; endproperty
	a_run: assert property (p_run) else $error("clock out stopped");
	property p_div; $fell(peripheral_divided_clocks[0]) |-> $changed(peripheral_divided_clocks[1]); endproperty
	a_div: assert property (p_div) else $error("divider chain broken");
	c_sw: cover property (p_sw);
	c_vec: cover property ($rose(vector_fetch));
	c_stop: cover property (stop_instruction ##1 !clock_out);
endmodule : rcg_monitor
bind reset_and_clock_gating rcg_monitor #(.POST_CYCLES(POST_CYCLES), .DIV_STAGES(DIV_STAGES)) u_mon (
	.clk(clk), .rst_n(rst_n), .reg_write(reg_write), .stop_instruction(stop_instruction),
	.wait_instruction(wait_instruction), .wake_event(wake_event), .ready_n(ready_n),
	.hold_accepted(hold_accepted), .bus_wait_request(bus_wait_request), .periph_reset_n(periph_reset_n),
	.ram_reset_n(ram_reset_n), .vector_fetch(vector_fetch), .main_clk_en(main_clk_en),
	.cpu_clk_en(cpu_clk_en), .clock_out(clock_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.vector_addr(vector_addr), .peripheral_divided_clocks(peripheral_divided_clocks)
);

/* verification/bus_side_model.sv */
// Bus unit model raising wait requests on command
`timescale 1ns/100ps
module bus_side_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic stall,
	output logic      bus_wait_request
);
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) bus_wait_request <= 1'b0;
		else bus_wait_request <= stall;
endmodule : bus_side_model

/* verification/tb.sv */
// Testbench for reset and clock gating
`timescale 1ns/100ps
module tb;
	logic clk = 0, rst_n = 0, reg_write = 0, stop_instruction = 0, wait_instruction = 0, wake_event = 0;
	logic ready_n = 1, hold_accepted = 0, stall = 0, bus_wait_request, periph_reset_n, ram_reset_n, co;
	logic vector_fetch, main_clk_en, cpu_clk_en, clock_out;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [15:0] vector_addr;
	logic [8:0] peripheral_divided_clocks, d0;
	int fails = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	reset_and_clock_gating #(.POST_CYCLES(4)) DUT (
		.clk(clk), .rst_n(rst_n), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.stop_instruction(stop_instruction), .wait_instruction(wait_instruction), .wake_event(wake_event),
		.ready_n(ready_n), .hold_accepted(hold_accepted), .bus_wait_request(bus_wait_request),
		.periph_reset_n(periph_reset_n), .ram_reset_n(ram_reset_n), .vector_fetch(vector_fetch),
		.vector_addr(vector_addr), .main_clk_en(main_clk_en), .cpu_clk_en(cpu_clk_en), .clock_out(clock_out),
		.peripheral_divided_clocks(peripheral_divided_clocks)
	);
	bus_side_model P (.clk(clk), .rst_n(rst_n), .stall(stall), .bus_wait_request(bus_wait_request));
	task check(input logic [16:0] seen, input logic [16:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop;
		$display("fails=%0d checks=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task t_vector;
		cyc(3); check(vector_fetch, 0);
		cyc(1); check({vector_fetch, vector_addr}, 17'h1fffe);
		cyc(1); check({vector_fetch, vector_addr}, 17'h1ffff);
		cyc(1); check(vector_fetch, 0);
	endtask : t_vector
	task t_soft(input logic [7:0] a, input logic [7:0] d, input logic hit);
		reg_addr = a; reg_wdata = d; reg_write = 1;
		cyc(1); reg_write = 0;
		check({periph_reset_n, ram_reset_n}, {~hit, 1'b1});
		cyc(1); check(periph_reset_n, 1);
		if (hit) t_vector();
	endtask : t_soft
	task t_gate(output logic [16:0] r);
		co = clock_out; cyc(1);
		r = {clock_out ^ co, main_clk_en, cpu_clk_en};
	endtask : t_gate
	task t_modes;
		logic [16:0] r;
		ready_n = 0; t_gate(r); t_gate(r); check(r, 3'b100); ready_n = 1;
		hold_accepted = 1; t_gate(r); t_gate(r); check(r, 3'b110); hold_accepted = 0;
		stall = 1; cyc(1); t_gate(r); check(r, 3'b110); stall = 0;
		cyc(1); t_gate(r); check(r, 3'b111);
		d0 = peripheral_divided_clocks; cyc(1); check(peripheral_divided_clocks, d0 + 9'h001);
		wait_instruction = 1; t_gate(r); wait_instruction = 0; t_gate(r); check(r, 3'b100);
		d0 = peripheral_divided_clocks; cyc(2); check(peripheral_divided_clocks, d0);
		wake_event = 1; t_gate(r); wake_event = 0; check(r[1:0], 2'b11);
		stop_instruction = 1; cyc(1); stop_instruction = 0; check({clock_out, main_clk_en}, 0);
		cyc(2); check(clock_out, 0);
		wake_event = 1; cyc(1); wake_event = 0; check(main_clk_en, 1);
	endtask : t_modes
	initial begin
		#20000 fails++;
		report_and_stop();
	end
	initial begin
		cyc(80);
		check({periph_reset_n, ram_reset_n, main_clk_en}, 3'b000);
		rst_n = 1; cyc(1); check({periph_reset_n, ram_reset_n}, 2'b11);
		t_vector();
		t_soft(8'h5e, 8'hf7, 0);
		t_soft(8'h5d, 8'h08, 0);
		t_soft(8'h5e, 8'h08, 1);
		t_modes();
		t_soft(8'h5e, 8'hff, 1);
		report_and_stop();
	end
endmodule : tb
